// >>> hdl/tmr_timer0.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmr_defs.svh"
// Functional notes
// R1: 8-bit counter reloads the programmed start value whenever it overflows.
// R2: write-only reload register, reset to zero, supplies the start value.
// R3: setting bit 4 runs the timer when one, stops it when zero.
// R4: setting bits 3..0 pick prescale divide by two to the power n.
// R5: software writes codes 0 to 8 only; larger codes act as divide by 256.
module tmr_timer0 (
   input  wire logic           sys_clk,
   input  wire logic           rst,
   input  wire logic           reg_wr,
   input  wire logic [7:0]     reg_addr,
   input  wire tmr_pkg::tmr_byte_t reg_wdata,
   output var  tmr_pkg::tmr_byte_t count,
   output logic                overflow
);
   import tmr_pkg::*;
   typedef struct packed {
      tmr_byte_t reload;
      tmr_byte_t setting;
      tmr_byte_t cnt;
      logic      ovf;
      logic [8:0] gap;
      tmr_psc_t  psc_prev;
   } tmr_state_s;
   tmr_state_s st_r;
   tmr_state_s st_nxt;
   tmr_psc_t   psc_eff;
   logic [8:0] gap_lim;
   tmr_tick_if tk ();
   tmr_prescaler u_psc (
      .sys_clk (sys_clk),
      .rst     (rst),
      .tk      (tk)
   );
   assign tk.run = st_r.setting[`TMR_EN_BIT]; // R3
   assign tk.psc = st_r.setting[`TMR_PSC_MSB:`TMR_PSC_LSB]; // R4
   always_comb begin
      // effective code and the longest legal distance between two ticks
      psc_eff    = (tk.psc > `TMR_PSC_MAX) ? `TMR_PSC_MAX : tk.psc; // R5
      gap_lim    = (9'h001 << psc_eff) - 9'h001; // R4
      st_nxt     = st_r;
      st_nxt.ovf = 1'b0;
      st_nxt.psc_prev = tk.psc;
      // the divider does not restart on a code change, so the gap count
      // restarts instead and the first period after a change may be short
      if (!tk.run || tk.tick || tk.psc != st_r.psc_prev)
         st_nxt.gap = 9'h000;
      else
         st_nxt.gap = st_r.gap + 9'h001;
      if (reg_wr && reg_addr == `TMR_RELOAD_OFS)
         st_nxt.reload = reg_wdata; // R2
      else if (reg_wr && reg_addr == `TMR_SETTING_OFS)
         st_nxt.setting = {3'h0, reg_wdata[4:0]};
      if (tk.tick) begin
         if (st_r.cnt == 8'hff) begin
            // the start value in force before this cycle's write is used
            st_nxt.cnt = st_r.reload; // R1
            st_nxt.ovf = 1'b1;
         end else begin
            st_nxt.cnt = st_r.cnt + 8'h01;
         end
      end
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_r.reload  <= `TMR_RELOAD_RST;
         st_r.setting <= `TMR_SETTING_RST;
         st_r.cnt     <= 8'h00;
         st_r.ovf     <= 1'b0;
         st_r.gap     <= 9'h000;
         st_r.psc_prev <= 4'h0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign count    = st_r.cnt;
   assign overflow = st_r.ovf;
   chk_reload_on_ovf: assert property (@(posedge sys_clk) disable iff (rst)
      (tk.tick && st_r.cnt == 8'hff) |=> (st_r.cnt == $past(st_r.reload) && st_r.ovf)) // R1
      else $error("overflow did not reload start value");
   chk_count_step: assert property (@(posedge sys_clk) disable iff (rst)
      (tk.tick && st_r.cnt != 8'hff) |=> st_r.cnt == $past(st_r.cnt) + 8'h01) // R1
      else $error("count did not step");
   chk_reload_write: assert property (@(posedge sys_clk) disable iff (rst)
      (reg_wr && reg_addr == `TMR_RELOAD_OFS) |=> st_r.reload == $past(reg_wdata)) // R2
      else $error("reload write lost");
   chk_stop_holds: assert property (@(posedge sys_clk) disable iff (rst)
      (!st_r.setting[4] ##1 !st_r.setting[4]) |-> $stable(st_r.cnt)) // R3
      else $error("count moved while stopped");
   chk_div2_rate: assert property (@(posedge sys_clk) disable iff (rst)
      (tk.tick && tk.psc == 4'h1 ##1 tk.psc == 4'h1 && tk.run) |-> !tk.tick) // R4
      else $error("divide by two ticked twice in a row");
   chk_high_code: assert property (@(posedge sys_clk) disable iff (rst)
      (tk.tick && tk.psc > 4'h8) |-> u_psc.st_r.div == 8'hff) // R5
      else $error("illegal code not treated as divide by 256");
   sequence s_wrap;
      tk.tick && st_r.cnt == 8'hff;
   endsequence
   sequence s_set_wr;
      reg_wr && reg_addr == `TMR_SETTING_OFS;
   endsequence
   sequence s_rld_wr;
      reg_wr && reg_addr == `TMR_RELOAD_OFS;
   endsequence
   chk_wrap_pulse: assert property (@(posedge sys_clk) disable iff (rst)
      s_wrap |=> st_r.ovf) // R1
      else $error("wrap without overflow pulse");
   chk_ovf_cause: assert property (@(posedge sys_clk) disable iff (rst)
      st_r.ovf |-> ($past(tk.tick) && $past(st_r.cnt) == 8'hff)) // R1
      else $error("overflow pulse without a wrap");
   chk_ovf_single: assert property (@(posedge sys_clk) disable iff (rst)
      (st_r.ovf && !(tk.tick && st_r.cnt == 8'hff)) |=> !st_r.ovf) // R1
      else $error("overflow pulse longer than one cycle");
   chk_idle_holds: assert property (@(posedge sys_clk) disable iff (rst)
      !tk.tick |=> $stable(st_r.cnt)) // R3
      else $error("count moved without a tick");
   chk_setting_write: assert property (@(posedge sys_clk) disable iff (rst)
      s_set_wr |=> st_r.setting == {3'h0, $past(reg_wdata[4:0])}) // R3
      else $error("setting write lost");
   chk_setting_keep: assert property (@(posedge sys_clk) disable iff (rst)
      !(reg_wr && reg_addr == `TMR_SETTING_OFS) |=> $stable(st_r.setting)) // R3
      else $error("setting changed without a write");
   chk_reload_keep: assert property (@(posedge sys_clk) disable iff (rst)
      !(reg_wr && reg_addr == `TMR_RELOAD_OFS) |=> $stable(st_r.reload)) // R2
      else $error("reload changed without a write");
   chk_reload_seq: assert property (@(posedge sys_clk) disable iff (rst)
      s_rld_wr |=> st_r.reload == $past(reg_wdata)) // R2
      else $error("reload write not taken");
   chk_gap_bound: assert property (@(posedge sys_clk) disable iff (rst)
      (tk.run && $stable(tk.psc)) |-> st_r.gap <= gap_lim) // R4
      else $error("prescaler period too long");
   chk_gap_due: assert property (@(posedge sys_clk) disable iff (rst)
      (tk.run && $stable(tk.psc) && st_r.gap == gap_lim) |-> tk.tick) // R4
      else $error("prescaler tick missing at end of period");
endmodule : tmr_timer0
`default_nettype wire

// >>> hdl/tmr_defs.svh
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH
`define TMR_ADDR_W         8
`define TMR_DATA_W         8
`define TMR_RELOAD_OFS     8'h01
`define TMR_SETTING_OFS    8'h02
`define TMR_RELOAD_RST     8'h00
`define TMR_SETTING_RST    8'h00
`define TMR_EN_BIT         4
`define TMR_PSC_MSB        3
`define TMR_PSC_LSB        0
`define TMR_PSC_MAX        4'h8
`endif

// >>> hdl/tmr_pkg.sv
`include "tmr_defs.svh"
package tmr_pkg;
   typedef logic [7:0] tmr_byte_t;
   typedef logic [3:0] tmr_psc_t;
endpackage : tmr_pkg

// >>> hdl/tmr_tick_if.sv
`timescale 1ns/10ps
`default_nettype none
interface tmr_tick_if;
   logic                 run;
   tmr_pkg::tmr_psc_t    psc;
   logic                 tick;
   modport ctl (output run, output psc, input tick);
   modport gen (input run, input psc, output tick);
endinterface : tmr_tick_if
`default_nettype wire

// >>> hdl/tmr_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmr_defs.svh"
module tmr_prescaler (
   input  wire logic sys_clk,
   input  wire logic rst,
   tmr_tick_if.gen   tk
);
   import tmr_pkg::*;
   typedef struct packed {
      logic [7:0] div;
   } tmr_psc_s;
   tmr_psc_s   st_r;
   tmr_psc_s   st_nxt;
   logic [7:0] mask;
   tmr_psc_t   code;
   always_comb begin
      // codes above the last legal one fall back to the slowest rate
      code = (tk.psc > `TMR_PSC_MAX) ? `TMR_PSC_MAX : tk.psc; // R5
      mask = 8'((9'h001 << code) - 9'h001); // R4
      st_nxt = st_r;
      if (!tk.run)
         st_nxt.div = 8'h00;
      else
         st_nxt.div = st_r.div + 8'h01;
      tk.tick = tk.run && ((st_r.div & mask) == mask); // R4
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end
   chk_tick_needs_run: assert property (@(posedge sys_clk) disable iff (rst) tk.tick |-> tk.run) // R3
      else $error("prescaler tick while stopped");
   chk_div1_every: assert property (@(posedge sys_clk) disable iff (rst)
      (tk.run && tk.psc == 4'h0) |-> tk.tick) // R4
      else $error("divide by one missed a tick");
endmodule : tmr_prescaler
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import tmr_pkg::*;
   logic       sys_clk     = 1'b0;
   logic       rst         = 1'b1;
   logic       reg_wr      = 1'b0;
   logic [7:0] reg_addr    = 8'h00;
   tmr_byte_t  reg_wdata   = 8'h00;
   tmr_byte_t  count;
   logic       overflow;
   int         miscompares = 0;
   int         checked     = 0;
   always #5 sys_clk = ~sys_clk;
   tmr_timer0 dut (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
                   .reg_wdata(reg_wdata), .count(count), .overflow(overflow));
   task automatic stop_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input tmr_byte_t d);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask : wr
   // cycles until the next overflow pulse, sampled after the edge settles
   task automatic wait_ovf(output int n);
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (overflow !== 1'b1 && n < 600);
      if (n >= 600) begin
         miscompares++;
         stop_test();
      end
   endtask : wait_ovf
   // first period after a setting change may be partial, so it is skipped
   task automatic period_is(input tmr_byte_t rl, input int exp);
      int n;
      wait_ovf(n);
      wait_ovf(n);
      chk("reload", {8'h00, rl}, {8'h00, count});
      wait_ovf(n);
      chk("period", exp[15:0], n[15:0]);
   endtask : period_is
   task automatic t_reset;
      chk("count", 16'h0000, {8'h00, count});
      chk("ovf", 16'h0000, {15'h0000, overflow});
      wr(8'h02, 8'h10);
      period_is(8'h00, 256);
   endtask : t_reset
   task automatic t_psc;
      wr(8'h01, 8'hff);
      for (int k = 0; k < 10; k++) begin
         wr(8'h02, 8'h10 | 8'(k));
         period_is(8'hff, (k > 8) ? 256 : (1 << k));
      end
   endtask : t_psc
   task automatic t_run_stop;
      tmr_byte_t c;
      wr(8'h01, 8'hfc);
      wr(8'h02, 8'h13);
      period_is(8'hfc, 32);
      wr(8'h03, 8'h00);
      period_is(8'hfc, 32);
      wr(8'h02, 8'h03);
      repeat (3) @(posedge sys_clk);
      #1;
      c = count;
      repeat (40) @(posedge sys_clk);
      #1;
      chk("held", {8'h00, c}, {8'h00, count});
      wr(8'h02, 8'h10);
      @(posedge sys_clk);
      #1;
      chk("resume", {8'h00, c + 8'h01}, {8'h00, count});
   endtask : t_run_stop
   task automatic t_mid_reset;
      wr(8'h01, 8'h80);
      wr(8'h02, 8'h10);
      repeat (20) @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("count after reset", 16'h0000, {8'h00, count});
      chk("ovf after reset", 16'h0000, {15'h0000, overflow});
      repeat (300) @(posedge sys_clk);
      #1;
      chk("stopped after reset", 16'h0000, {8'h00, count});
      wr(8'h02, 8'h10);
      period_is(8'h00, 256);
   endtask : t_mid_reset
   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      #1;
      t_reset();
      t_psc();
      t_run_stop();
      t_mid_reset();
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
